/* include/lid_recal_pkg.sv */
// constants for the lid closure and recalibration configuration block
// assumes a single 200 MHz clock domain and a byte-wide register port
package lid_recal_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LID_CONFIG   = 8'h2B;
    localparam logic [7:0] ADDR_LID_QUEUE    = 8'h2C;
    localparam logic [7:0] ADDR_PATTERN_BTN  = 8'h2D;
    localparam logic [7:0] ADDR_PATTERN_GRP  = 8'h2E;
    localparam logic [7:0] ADDR_RECAL_CONFIG = 8'h2F;
    localparam logic [7:0] ADDR_THRESH_FIRST = 8'h30;
    localparam logic [7:0] ADDR_THRESH_GROUP = 8'h37;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LID_CONFIG   = 8'h00;
    localparam logic [7:0] RST_LID_QUEUE    = 8'h02;
    localparam logic [7:0] RST_PATTERN      = 8'h7F;
    localparam logic [7:0] RST_RECAL_CONFIG = 8'h93;
    localparam logic [6:0] RST_THRESH       = 7'h40;
    localparam logic [7:0] MASK_LID_CONFIG  = 8'h83;
    localparam logic [7:0] MASK_LID_QUEUE   = 8'h07;
    localparam logic [7:0] MASK_PATTERN     = 8'h7F;
    localparam logic [7:0] MASK_RECAL       = 8'hDF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_LID_ENABLE       = 7;
    localparam int BIT_PATTERN_MODE     = 1;
    localparam int BIT_LID_ALERT_ENABLE = 0;
    localparam int BIT_BTN_BROADCAST    = 7;
    localparam int BIT_GRP_BROADCAST    = 6;
    localparam int POS_NEG_LIMIT        = 3;
    localparam int POS_CAL_CODE         = 0;
    localparam int POS_QUEUE            = 0;

    // ------------------------------------------------------------
    // negative delta run lengths
    // ------------------------------------------------------------
    localparam logic [1:0] NEG_CODE_DISABLED = 2'h3;
    localparam logic [5:0] NEG_RUN_8         = 6'h08;
    localparam logic [5:0] NEG_RUN_16        = 6'h10;
    localparam logic [5:0] NEG_RUN_32        = 6'h20;

    // ------------------------------------------------------------
    // recalibration samples and update intervals (polling cycles)
    // ------------------------------------------------------------
    localparam logic [8:0]  CAL_SAMPLES_16  = 9'h010;
    localparam logic [8:0]  CAL_SAMPLES_256 = 9'h100;
    localparam logic [12:0] CAL_UPD_16      = 13'h0010;
    localparam logic [12:0] CAL_UPD_32      = 13'h0020;
    localparam logic [12:0] CAL_UPD_64      = 13'h0040;
    localparam logic [12:0] CAL_UPD_256     = 13'h0100;
    localparam logic [12:0] CAL_UPD_1024    = 13'h0400;
    localparam logic [12:0] CAL_UPD_2048    = 13'h0800;
    localparam logic [12:0] CAL_UPD_4096    = 13'h1000;
    localparam logic [12:0] CAL_UPD_7936    = 13'h1F00;

    // ------------------------------------------------------------
    // event evaluation sequence
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        EVAL_IDLE  = 1'b0,
        EVAL_CHECK = 1'b1
    } eval_state_e;

endpackage

/* rtl/lid_sample_queue.sv */
// consecutive-sample qualifier for the per-sensor lid status bits
// assumes sample_strobe pulses once per polling cycle on sys_clk
`timescale 1ns/1ps
module lid_sample_queue (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // samples
    input  wire logic        sample_strobe,
    input  wire logic [13:0] above,
    input  wire logic [2:0]  queue_code,
    // qualified status
    output logic      [13:0] status
);

    // ------------------------------------------------------------
    // queue length
    // ------------------------------------------------------------
    // code 0 and code 1 both mean one sample
    wire logic [3:0] queue_len = (queue_code == 3'h0) ? 4'h1 : {1'b0, queue_code}; // R10 R11

    logic [3:0] run [14];

    // ------------------------------------------------------------
    // per-sensor run counters
    // ------------------------------------------------------------
    // runs count disagreeing samples: one queue sets and clears
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status <= 14'h0000;
            for (int i = 0; i < 14; i++) begin
                run[i] <= 4'h0;
            end
        end else if (sample_strobe) begin
            for (int i = 0; i < 14; i++) begin
                if (above[i] == status[i]) begin
                    run[i] <= 4'h0;
                end else if (run[i] + 4'h1 >= queue_len) begin // R12
                    run[i]    <= 4'h0;
                    status[i] <= above[i]; // R10
                end else begin
                    run[i] <= run[i] + 4'h1;
                end
            end
        end
    end

endmodule

/* rtl/lid_recal_control.sv */
// lid closure detection and recalibration configuration for a 14-input touch controller
// assumes a same-clock serial-bus engine and sensor front end
//
// Function
// R1 - lid detection only while enable bit set; the queue and lid_status still update while it is clear
// R2 - combine lid status, patterns; noise joins lid
// R3 - pattern mode: all pattern bits present
// R4 - count mode: sensors 1-7 meet pattern count
// R5 - count mode: sensors 8-14 meet pattern count
// R6 - count mode: totals compared; any condition flags
// R7 - both patterns zero disables, clears event
// R8 - alert only when lid alert enabled
// R9 - flagged event reported to group status
// R10 - status set after queued consecutive samples
// R11 - queue code zero means one sample
// R12 - queue per sensor, setting and clearing
// R13 - two seven-bit masks reset to all ones
// R14 - patterns consulted only while enabled
// R15 - sensor 1 write broadcasts to buttons
// R16 - sensor 1 write optionally sets group
// R17 - negative delta run triggers recalibration
// R18 - code selects samples and update interval
// R19 - average selected samples before base update
// R20 - update interval counted in polling cycles
// R21 - one timing for all, enables per sensor
// R22 - above lid threshold when output exceeds
// R23 - evaluate event once after status update
`timescale 1ns/1ps
module lid_recal_control (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_wdata,
    output logic      [7:0]   reg_rdata,
    // sensor front end
    input  wire logic         sample_strobe,
    input  wire logic [111:0] sensor_delta,
    input  wire logic [97:0]  lid_level,
    input  wire logic [13:0]  noise_flags,
    input  wire logic [13:0]  neg_delta,
    // recalibration timing
    input  wire logic         poll_tick,
    input  wire logic [13:0]  recal_enable,
    // lid results
    output logic      [13:0]  lid_status,
    output logic      [13:0]  lid_noise_status,
    output logic              lid_event,
    output logic              lid_event_pulse,
    output logic              lid_alert,
    // thresholds
    output logic      [55:0]  sensor_threshold,
    // recalibration
    output logic      [13:0]  recal_trigger,
    output logic      [13:0]  base_update,
    output logic      [8:0]   recal_samples
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [2:0] count_ones(input logic [6:0] v);
        return 3'($countones(v));
    endfunction

    function automatic logic [5:0] neg_run_len(input logic [1:0] code);
        case (code)
            2'h0:    return lid_recal_pkg::NEG_RUN_8;
            2'h1:    return lid_recal_pkg::NEG_RUN_16;
            default: return lid_recal_pkg::NEG_RUN_32;
        endcase
    endfunction

    function automatic logic [12:0] update_interval(input logic [2:0] code);
        case (code)
            3'h0:    return lid_recal_pkg::CAL_UPD_16;
            3'h1:    return lid_recal_pkg::CAL_UPD_32;
            3'h2:    return lid_recal_pkg::CAL_UPD_64;
            3'h3:    return lid_recal_pkg::CAL_UPD_256;
            3'h4:    return lid_recal_pkg::CAL_UPD_1024;
            3'h5:    return lid_recal_pkg::CAL_UPD_2048;
            3'h6:    return lid_recal_pkg::CAL_UPD_4096;
            default: return lid_recal_pkg::CAL_UPD_7936;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] lid_closure_config;
    logic [7:0] lid_queue_control;
    logic [7:0] lid_pattern_buttons;
    logic [7:0] lid_pattern_grouped;
    logic [7:0] recalibration_config;
    logic [6:0] threshold [8];

    wire logic       lid_enable                 = lid_closure_config[lid_recal_pkg::BIT_LID_ENABLE];
    wire logic       pattern_match_mode         = lid_closure_config[lid_recal_pkg::BIT_PATTERN_MODE];
    wire logic       lid_alert_enable           = lid_closure_config[lid_recal_pkg::BIT_LID_ALERT_ENABLE];
    wire logic       button_threshold_broadcast = recalibration_config[lid_recal_pkg::BIT_BTN_BROADCAST];
    wire logic       group_threshold_broadcast  = recalibration_config[lid_recal_pkg::BIT_GRP_BROADCAST];
    wire logic [1:0] negative_delta_limit       = recalibration_config[lid_recal_pkg::POS_NEG_LIMIT +: 2];
    wire logic [2:0] cal_code                   = recalibration_config[lid_recal_pkg::POS_CAL_CODE +: 3];
    wire logic [2:0] queue_code                 = lid_queue_control[lid_recal_pkg::POS_QUEUE +: 3];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic hit_config  = reg_addr == lid_recal_pkg::ADDR_LID_CONFIG;
    wire logic hit_queue   = reg_addr == lid_recal_pkg::ADDR_LID_QUEUE;
    wire logic hit_pat_btn = reg_addr == lid_recal_pkg::ADDR_PATTERN_BTN;
    wire logic hit_pat_grp = reg_addr == lid_recal_pkg::ADDR_PATTERN_GRP;
    wire logic hit_recal   = reg_addr == lid_recal_pkg::ADDR_RECAL_CONFIG;
    wire logic hit_thresh  = (reg_addr >= lid_recal_pkg::ADDR_THRESH_FIRST)
                           && (reg_addr <= lid_recal_pkg::ADDR_THRESH_GROUP);
    wire logic [2:0] thresh_index = reg_addr[2:0];
    wire logic sensor1_write = reg_wr && (reg_addr == lid_recal_pkg::ADDR_THRESH_FIRST);

    wire logic [7:0] read_mux =
        hit_config  ? lid_closure_config :
        hit_queue   ? lid_queue_control :
        hit_pat_btn ? lid_pattern_buttons :
        hit_pat_grp ? lid_pattern_grouped :
        hit_recal   ? recalibration_config :
        hit_thresh  ? {1'b0, threshold[thresh_index]} :
                      8'h00;

    // ------------------------------------------------------------
    // configuration writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lid_closure_config   <= lid_recal_pkg::RST_LID_CONFIG; // R1
            lid_queue_control    <= lid_recal_pkg::RST_LID_QUEUE;
            lid_pattern_buttons  <= lid_recal_pkg::RST_PATTERN; // R13
            lid_pattern_grouped  <= lid_recal_pkg::RST_PATTERN; // R13
            recalibration_config <= lid_recal_pkg::RST_RECAL_CONFIG;
            reg_rdata            <= 8'h00;
        end else begin
            if (reg_wr && hit_config) lid_closure_config <= reg_wdata & lid_recal_pkg::MASK_LID_CONFIG;
            if (reg_wr && hit_queue) lid_queue_control <= reg_wdata & lid_recal_pkg::MASK_LID_QUEUE;
            if (reg_wr && hit_pat_btn) lid_pattern_buttons <= reg_wdata & lid_recal_pkg::MASK_PATTERN;
            if (reg_wr && hit_pat_grp) lid_pattern_grouped <= reg_wdata & lid_recal_pkg::MASK_PATTERN;
            if (reg_wr && hit_recal) recalibration_config <= reg_wdata & lid_recal_pkg::MASK_RECAL;
            if (reg_rd) reg_rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // threshold registers with broadcast
    // ------------------------------------------------------------
    // a direct write later replaces a broadcast value
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 8; i++) begin
                threshold[i] <= lid_recal_pkg::RST_THRESH;
            end
        end else if (reg_wr && hit_thresh) begin
            threshold[thresh_index] <= reg_wdata[6:0];
            if (sensor1_write && button_threshold_broadcast) begin
                for (int i = 1; i < 7; i++) begin
                    threshold[i] <= reg_wdata[6:0]; // R15
                end
            end
            if (sensor1_write && group_threshold_broadcast) begin
                threshold[7] <= reg_wdata[6:0]; // R16
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sensor_threshold <= {8{lid_recal_pkg::RST_THRESH}};
        end else begin
            for (int i = 0; i < 8; i++) begin
                sensor_threshold[i*7 +: 7] <= threshold[i];
            end
        end
    end

    // ------------------------------------------------------------
    // lid threshold compare and queue
    // ------------------------------------------------------------
    logic [13:0] above;
    for (genvar g = 0; g < 14; g++) begin : g_above
        assign above[g] = sensor_delta[g*8 +: 8] > {1'b0, lid_level[g*7 +: 7]}; // R22
    end

    logic [13:0] queued_status;
    lid_sample_queue u_queue (
        .sys_clk       (sys_clk),
        .nrst          (nrst),
        .sample_strobe (sample_strobe),
        .above         (above),
        .queue_code    (queue_code),
        .status        (queued_status)
    );

    // ------------------------------------------------------------
    // event decision
    // ------------------------------------------------------------
    wire logic [6:0] status_btn = queued_status[6:0];
    wire logic [6:0] status_grp = queued_status[13:7];
    wire logic [6:0] pat_btn    = lid_pattern_buttons[6:0];
    wire logic [6:0] pat_grp    = lid_pattern_grouped[6:0];
    wire logic [2:0] cnt_sb     = count_ones(status_btn);
    wire logic [2:0] cnt_sg     = count_ones(status_grp);
    wire logic [2:0] cnt_pb     = count_ones(pat_btn);
    wire logic [2:0] cnt_pg     = count_ones(pat_grp);
    wire logic [3:0] cnt_s_all  = {1'b0, cnt_sb} + {1'b0, cnt_sg};
    wire logic [3:0] cnt_p_all  = {1'b0, cnt_pb} + {1'b0, cnt_pg};

    wire logic match_exact = ((status_btn & pat_btn) == pat_btn) && ((status_grp & pat_grp) == pat_grp); // R3
    wire logic match_count = (cnt_sb >= cnt_pb) // R4
                           || (cnt_sg >= cnt_pg) // R5
                           || (cnt_s_all >= cnt_p_all); // R6
    wire logic patterns_zero = (pat_btn == 7'h00) && (pat_grp == 7'h00); // R7
    wire logic event_now = lid_enable && !patterns_zero // R1 R14
                         && (pattern_match_mode ? match_exact : match_count); // R2

    lid_recal_pkg::eval_state_e eval_state;
    lid_recal_pkg::eval_state_e next_eval_state;

    always_comb begin
        case (eval_state)
            lid_recal_pkg::EVAL_IDLE,
            lid_recal_pkg::EVAL_CHECK: next_eval_state = sample_strobe ? lid_recal_pkg::EVAL_CHECK
                                                                       : lid_recal_pkg::EVAL_IDLE;
            default:                   next_eval_state = lid_recal_pkg::EVAL_IDLE;
        endcase
    end

    // check a cycle after the strobe, once all queued bits settle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            eval_state       <= lid_recal_pkg::EVAL_IDLE;
            lid_event        <= 1'b0;
            lid_event_pulse  <= 1'b0;
            lid_alert        <= 1'b0;
            lid_status       <= 14'h0000;
            lid_noise_status <= 14'h0000;
        end else begin
            eval_state       <= next_eval_state;
            lid_status       <= queued_status;
            lid_noise_status <= lid_enable ? noise_flags : 14'h0000; // R2
            lid_event_pulse  <= 1'b0;
            if (!lid_enable || patterns_zero) begin
                lid_event <= 1'b0; // R7
                lid_alert <= 1'b0;
            end else if (eval_state == lid_recal_pkg::EVAL_CHECK) begin
                lid_event       <= event_now; // R23 R9
                lid_event_pulse <= event_now && !lid_event; // R9
                lid_alert       <= event_now && lid_alert_enable; // R8
            end
        end
    end

    // ------------------------------------------------------------
    // negative delta recalibration trigger
    // ------------------------------------------------------------
    logic [5:0] neg_run [14];
    wire logic [5:0] neg_limit    = neg_run_len(negative_delta_limit);
    wire logic       neg_disabled = negative_delta_limit == lid_recal_pkg::NEG_CODE_DISABLED;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            recal_trigger <= 14'h0000;
            for (int i = 0; i < 14; i++) begin
                neg_run[i] <= 6'h00;
            end
        end else begin
            recal_trigger <= 14'h0000;
            for (int i = 0; i < 14; i++) begin
                if (neg_disabled) begin
                    neg_run[i] <= 6'h00; // R17
                end else if (sample_strobe) begin
                    if (!neg_delta[i]) begin
                        neg_run[i] <= 6'h00;
                    end else if (neg_run[i] + 6'h01 >= neg_limit) begin
                        neg_run[i]       <= 6'h00;
                        recal_trigger[i] <= 1'b1; // R17
                    end else begin
                        neg_run[i] <= neg_run[i] + 6'h01;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // base count update timing
    // ------------------------------------------------------------
    logic [12:0] poll_count;
    wire logic [12:0] interval = update_interval(cal_code); // R18
    wire logic [8:0] samples_sel = (cal_code > 3'h2) ? lid_recal_pkg::CAL_SAMPLES_256
                                                     : 9'(lid_recal_pkg::CAL_SAMPLES_16 << cal_code); // R18

    // >= so a shortened interval takes effect at once
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            poll_count    <= 13'h0000;
            base_update   <= 14'h0000;
            recal_samples <= lid_recal_pkg::CAL_SAMPLES_256;
        end else begin
            recal_samples <= samples_sel; // R19 R21
            base_update   <= 14'h0000;
            if (poll_tick) begin
                if (poll_count + 13'h0001 >= interval) begin // R20
                    poll_count  <= 13'h0000;
                    base_update <= recal_enable; // R21 R19
                end else begin
                    poll_count <= poll_count + 13'h0001;
                end
            end
        end
    end

endmodule

/* test/lid_recal_chk.sv */
// port assertions for the lid closure and recalibration block
// assumes one clock domain; bound from the bench top file
`timescale 1ns/1ps
module lid_recal_chk (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         nrst,
    // register port and samples
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_rdata,
    input wire logic         sample_strobe,
    input wire logic [13:0]  recal_enable,
    // results
    input wire logic [13:0]  lid_status,
    input wire logic         lid_event,
    input wire logic         lid_event_pulse,
    input wire logic         lid_alert,
    input wire logic [55:0]  sensor_threshold,
    input wire logic [13:0]  recal_trigger,
    input wire logic [13:0]  base_update,
    input wire logic [8:0]   recal_samples
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_alert; lid_alert |-> lid_event; endproperty
    a_alert: assert property (p_alert) else $error("alert without lid event");
    property p_pulse; lid_event_pulse |-> lid_event && !$past(lid_event); endproperty
    a_pulse: assert property (p_pulse) else $error("event pulse not on a rise");
    property p_rise; $rose(lid_event) |-> $past(sample_strobe, 2) || $past(sample_strobe, 3); endproperty
    a_rise: assert property (p_rise) else $error("event rose away from evaluation");
    property p_stat; $changed(lid_status) |-> $past(sample_strobe, 2); endproperty
    a_stat: assert property (p_stat) else $error("lid status moved without sample");
    property p_thr; $changed(sensor_threshold) |-> $past(reg_wr, 2); endproperty
    a_thr: assert property (p_thr) else $error("threshold moved without write");
    property p_rdat; $changed(reg_rdata) |-> $past(reg_rd); endproperty
    a_rdat: assert property (p_rdat) else $error("read data moved without read");
    property p_base; |base_update |-> base_update == $past(recal_enable); endproperty
    a_base: assert property (p_base) else $error("base update ignores enables");
    property p_samp; recal_samples inside {9'h010, 9'h020, 9'h040, 9'h100}; endproperty
    a_samp: assert property (p_samp) else $error("illegal sample count");
    property p_trig; |recal_trigger |-> ($past(sample_strobe) || $past(sample_strobe, 2)) ##1 recal_trigger == 0; endproperty
    a_trig: assert property (p_trig) else $error("bad recalibration trigger");
endmodule

/* test/host_model.sv */
// host side model: single byte register writes and reads
// assumes the design takes requests on the rising edge of sys_clk
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic       sys_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h00000;
    end
    // released address and data show the inverse and wr, rd drop low so a stale value never reads as valid
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge sys_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(negedge sys_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~d, 2'b00};
    endtask
endmodule

/* test/lid_recal_control_tb_top.sv */
// bench top: host model, sensor stimulus and self checks
// assumes the checker and host model compile first
`timescale 1ns/1ps
module lid_recal_control_tb_top;
    logic         sys_clk = 1'b0, nrst = 1'b0, rd_seen = 1'b0, trig_seen = 1'b0;
    logic         reg_wr, reg_rd, sample_strobe = 1'b0, poll_tick = 1'b0, lid_event, lid_event_pulse, lid_alert;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, exp_q[$];
    logic [111:0] sensor_delta = '0;
    logic [13:0]  noise_flags = 14'h2A5A, neg_delta = 14'h0000, lid_status, lid_noise_status, recal_trigger, base_update;
    logic [13:0]  recal_enable = 14'h3FFF;
    logic [55:0]  sensor_threshold;
    logic [8:0]   recal_samples;
    int           n_mismatch = 0, samples_checked = 0, seed = 78273;

    host_model host_model_i (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
    lid_recal_control lid_recal_control_i (.sys_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .sample_strobe, .sensor_delta, .lid_level({14{7'h10}}), .noise_flags, .neg_delta, .poll_tick,
        .recal_enable, .lid_status, .lid_noise_status, .lid_event, .lid_event_pulse, .lid_alert,
        .sensor_threshold, .recal_trigger, .base_update, .recal_samples);

    always #2.5 sys_clk = !sys_clk;
    always @(negedge sys_clk) poll_tick <= !poll_tick;
    always @(negedge sys_clk) recal_enable <= 14'($random(seed));
    always @(posedge sys_clk) begin
        rd_seen   <= reg_rd;
        trig_seen <= trig_seen | recal_trigger[0];
        if (rd_seen) check("rdata", reg_rdata, exp_q.pop_front());
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_i.access(a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_model_i.access(a, 8'h00, 1'b0);
    endtask
    task automatic strobe(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            sample_strobe = 1'b1;
            @(negedge sys_clk);
            sample_strobe = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
    endtask
    // 8'h10 sits on the strict-above boundary
    task automatic ev(input logic [13:0] m, input logic e, input logic a);
        for (int i = 0; i < 14; i++) sensor_delta[i*8+:8] = m[i] ? 8'($random(seed)) | 8'h11 : 8'h10;
        strobe(1);
        check("event", lid_event, e);
        check("alert", lid_alert, a);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        rd(8'h2B, 8'h00);
        rd(8'h2C, 8'h02);
        rd(8'h2D, 8'h7F);
        rd(8'h2E, 8'h7F);
        rd(8'h2F, 8'h93);
        rd(8'h50, 8'h00);
        ev(14'h0001, 1'b0, 1'b0);
        check("status", lid_status, 14'h0000);
        strobe(1);
        check("status", lid_status, 14'h0001);
        ev(14'h0000, 1'b0, 1'b0);
        check("status", lid_status, 14'h0001);
        strobe(1);
        check("status", lid_status, 14'h0000);
        check("noise", lid_noise_status, 14'h0000);
        $display("queue test done");
        wr(8'h2C, 8'h00);
        wr(8'h2D, 8'h03);
        wr(8'h2E, 8'h00);
        wr(8'h2B, 8'h82);
        ev(14'h0003, 1'b1, 1'b0);
        check("noise", lid_noise_status, 14'h2A5A);
        ev(14'h0001, 1'b0, 1'b0);
        wr(8'h2B, 8'h83);
        ev(14'h0003, 1'b1, 1'b1);
        wr(8'h2B, 8'h81);
        wr(8'h2D, 8'h07);
        wr(8'h2E, 8'h7F);
        ev(14'h0070, 1'b1, 1'b1);
        ev(14'h0030, 1'b0, 1'b0);
        ev(14'h1F80, 1'b0, 1'b0);
        ev(14'h3F80, 1'b1, 1'b1);
        wr(8'h2D, 8'h00);
        wr(8'h2E, 8'h00);
        repeat (2) @(negedge sys_clk);
        check("event", lid_event, 1'b0);
        wr(8'h2D, 8'h07);
        ev(14'h0070, 1'b1, 1'b1);
        wr(8'h2B, 8'h01);
        repeat (2) @(negedge sys_clk);
        check("event", lid_event, 1'b0);
        wr(8'h2B, 8'hFF);
        rd(8'h2B, 8'h83);
        $display("lid test done");
        wr(8'h30, 8'h25);
        for (int a = 8'h30; a < 8'h37; a++) rd(8'(a), 8'h25);
        rd(8'h37, 8'h40);
        check("thr", 16'(sensor_threshold[42+:7]), 16'h0025);
        wr(8'h33, 8'h05);
        wr(8'h2F, 8'hD3);
        wr(8'h30, 8'hF1);
        rd(8'h37, 8'h71);
        rd(8'h33, 8'h71);
        $display("threshold test done");
        wr(8'h2F, 8'hFF);
        rd(8'h2F, 8'hDF);
        wr(8'h2F, 8'h80);
        neg_delta = 14'h0001;
        strobe(7);
        check("trig", trig_seen, 1'b0);
        strobe(1);
        check("trig", trig_seen, 1'b1);
        neg_delta = 14'h0000;
        for (int c = 0; c < 8; c++) begin
            wr(8'h2F, 8'(c));
            @(negedge sys_clk);
            check("samples", recal_samples, c < 3 ? 16 << c : 256);
        end
        repeat (4) @(negedge sys_clk);
        $display("recal test done");
        report_and_stop;
    end
endmodule

bind lid_recal_control lid_recal_chk lid_recal_chk_i (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_rdata,
    .sample_strobe, .recal_enable, .lid_status, .lid_event, .lid_event_pulse, .lid_alert, .sensor_threshold,
    .recal_trigger, .base_update, .recal_samples);
